/* core/zce_pkg.sv */
// Shared constants for the zero clamp and encoder output block
package zce_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ZCE_OFS_MODE = 8'h00;
  localparam logic [7:0] ZCE_OFS_LEVEL = 8'h04;
  localparam logic [7:0] ZCE_OFS_MAXSPD = 8'h08;
  localparam logic [7:0] ZCE_OFS_DIVSET = 8'h0c;
  localparam logic [7:0] ZCE_OFS_CTRL = 8'h10;
  localparam logic [7:0] ZCE_OFS_STATUS = 8'h14;
  localparam logic [7:0] ZCE_OFS_POS = 8'h18;
  localparam logic [7:0] ZCE_OFS_HOLD = 8'h1c;
  localparam logic [7:0] ZCE_OFS_DIVACT = 8'h20;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ZCE_CTRL_ABS_BIT = 0;
  localparam int ZCE_CTRL_APPLY_BIT = 1;
  localparam int ZCE_CTRL_ROUTE_LSB = 4;
  localparam int ZCE_CTRL_GAIN_LSB = 8;
  localparam int ZCE_ST_CLAMP_BIT = 0;
  localparam int ZCE_ST_SENSE_BIT = 1;
  localparam int ZCE_ST_SAME_BIT = 2;

  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam logic [3:0] ZCE_MODE_RST = 4'h0;
  localparam logic [3:0] ZCE_MODE_ZCLAMP = 4'ha;
  localparam logic [13:0] ZCE_LEVEL_RST = 14'h000a;
  localparam logic [13:0] ZCE_LEVEL_MAX = 14'h2710;
  localparam logic [13:0] ZCE_MAXSPD_RST = 14'h0bb8;
  localparam logic [15:0] ZCE_DIV_RST = 16'h09c4;
  localparam logic [15:0] ZCE_DIV_MIN = 16'h0010;
  localparam int ZCE_DIV_MAX = 32768;
  localparam int ZCE_ENC_PPR_DEF = 32768;
  localparam logic [1:0] ZCE_ROUTE_RST = 2'h0;
  localparam logic [3:0] ZCE_GAIN_RST = 4'h2;

endpackage : zce_pkg

/* core/zce_pulse_div.sv */
// Encoder feedback pulse divider producing a quadrature pair
`timescale 1ns/1ns
module zce_pulse_div
  import zce_pkg::*;
#(
  parameter int ENC_PPR = ZCE_ENC_PPR_DEF
)
(
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_step, // One feedback edge
  input wire logic i_dir, // High for forward
  input wire logic [15:0] i_divisor, // Output pulses per rev
  output logic o_a, // Divided phase A
  output logic o_b // Divided phase B
);

  localparam logic [17:0] PPR_W = 18'(ENC_PPR);

  typedef struct packed {
    logic [16:0] acc;
    logic [1:0] phase;
    logic a;
    logic b;
  } zce_div_st_t;

  zce_div_st_t st_reg;
  zce_div_st_t st_next;

  always_comb
  begin
    logic [17:0] sum;
    sum = {1'b0, st_reg.acc} + {2'b00, i_divisor};
    st_next = st_reg;
    if (i_step)
    begin
      if (i_dir)
      begin
        if (sum >= PPR_W)
        begin
          st_next.acc = 17'(sum - PPR_W);
          st_next.phase = st_reg.phase + 2'h1;
        end
        else
        begin
          st_next.acc = sum[16:0];
        end
      end
      else if ({1'b0, st_reg.acc} < {1'b0, i_divisor})
      begin
        st_next.acc = 17'({1'b0, st_reg.acc} + PPR_W - {2'b00, i_divisor});
        st_next.phase = st_reg.phase - 2'h1;
      end
      else
      begin
        st_next.acc = st_reg.acc - {1'b0, i_divisor};
      end
    end
    // Gray sequence keeps A and B a quarter cycle apart
    st_next.a = st_next.phase[1];
    st_next.b = st_next.phase[1] ^ st_next.phase[0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_a = st_reg.a;
  assign o_b = st_reg.b;

endmodule : zce_pulse_div

/* core/zce_zero_clamp_top.sv */
// Zero clamp, encoder divided output and speed match output
`timescale 1ns/1ns

// Contract
// - Clamp request plus slow reference locks position
// - Hold within one pulse of clamp point
// - Drive back after external displacement
// - Clamp only in zero clamp mode
// - Clamp level 0 to 10000, default 10
// - Level limited to motor maximum speed
// - Clamp request is active low
// - Differential A, B and index outputs
// - Divider 16 to 32768, applied on restart
// - Sense input honoured only for absolute encoder
// - Speed match output low when speeds match
// - Speed match routable to output terminals
module zce_zero_clamp_top
  import zce_pkg::*;
#(
  parameter int ENC_PPR = ZCE_ENC_PPR_DEF
)
(
  input wire logic i_clk, // System clock, 10 MHz
  input wire logic i_rst, // Synchronous reset
  input wire logic [7:0] i_addr, // Register byte address
  input wire logic [31:0] i_wdata, // Register write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after strobe
  input wire logic i_clamp_request_n, // Clamp request pin
  input wire logic i_enc_a, // Encoder phase A pin
  input wire logic i_enc_b, // Encoder phase B pin
  input wire logic i_enc_index, // Encoder index pin
  input wire logic i_absolute_sense_input, // Absolute sense pin
  input wire logic [15:0] i_speed_ref, // Speed reference, r/min
  input wire logic i_speed_same, // Speed loop at same speed
  output logic [15:0] o_speed_cmd, // Speed command to loop
  output logic o_clamp_active, // Position is locked
  output logic o_abs_sense, // Honoured sense level
  output logic o_enc_out_a_pos, // Phase A true
  output logic o_enc_out_a_neg, // Phase A complement
  output logic o_enc_out_b_pos, // Phase B true
  output logic o_enc_out_b_neg, // Phase B complement
  output logic o_enc_out_index_pos, // Index true
  output logic o_enc_out_index_neg, // Index complement
  output logic [3:0] o_out_term_n // Output terminals, active low
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ENC_PPR < 16 || ENC_PPR > ZCE_DIV_MAX)
  begin : g_bad_ppr
    $error("ENC_PPR out of range");
  end

  localparam logic [15:0] PPR_LIM = 16'(ENC_PPR - 1) + 16'h0001;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic sen_s1;
    logic sen_s2;
    logic a_old;
    logic b_old;
    logic [31:0] pos;
    logic [31:0] hold;
    logic clamp;
    logic [3:0] mode;
    logic [13:0] level;
    logic [13:0] maxspd;
    logic [15:0] div_set;
    logic [15:0] div_act;
    logic abs_en;
    logic [1:0] route;
    logic [3:0] gain;
    logic [31:0] rdata;
    logic [15:0] cmd;
    logic [3:0] term_n;
    logic sense;
    logic [5:0] enc_o;
  } zce_st_t;

  zce_st_t st_reg;
  zce_st_t st_next;

  logic div_a;
  logic div_b;
  logic step;
  logic dir;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] mag32(input logic [31:0] v);
    mag32 = v[31] ? (~v + 32'h1) : v;
  endfunction : mag32

  function automatic logic [15:0] sat16(input logic [47:0] v);
    if (!v[47] && v[46:15] != 32'h0)
    begin
      sat16 = 16'h7fff;
    end
    else if (v[47] && v[46:15] != 32'hffffffff)
    begin
      sat16 = 16'h8000;
    end
    else
    begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  function automatic logic [15:0] div_clip(input logic [15:0] v);
    if (v < ZCE_DIV_MIN)
    begin
      div_clip = ZCE_DIV_MIN;
    end
    else if (v > PPR_LIM)
    begin
      div_clip = PPR_LIM;
    end
    else
    begin
      div_clip = v;
    end
  endfunction : div_clip

  // ----------------------------------------
  // Feedback decode
  // ----------------------------------------
  // Both phases moving at once is a lost edge; it is dropped
  assign step = (st_reg.s2[0] ^ st_reg.a_old) ^ (st_reg.s2[1] ^ st_reg.b_old);
  assign dir = st_reg.a_old ^ st_reg.s2[1];

  zce_pulse_div #(
    .ENC_PPR(ENC_PPR)
  ) u_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_step(step),
    .i_dir(dir),
    .i_divisor(st_reg.div_act),
    .o_a(div_a),
    .o_b(div_b)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [13:0] thr;
    logic [31:0] ref_mag;
    logic [31:0] err;
    logic [47:0] scaled;
    logic req;
    logic want;
    st_next = st_reg;
    thr = '0;
    ref_mag = '0;
    err = '0;
    scaled = '0;
    req = 1'b0;
    want = 1'b0;

    // Pins pass two flops before use
    st_next.s1 = {i_enc_index, i_clamp_request_n, i_enc_b, i_enc_a};
    st_next.s2 = st_reg.s1;
    st_next.sen_s1 = i_absolute_sense_input;
    st_next.sen_s2 = st_reg.sen_s1;
    st_next.a_old = st_reg.s2[0];
    st_next.b_old = st_reg.s2[1];

    if (step)
    begin
      st_next.pos = dir ? st_reg.pos + 32'h1 : st_reg.pos - 32'h1;
    end

    // Clamp decision
    thr = (st_reg.level > st_reg.maxspd) ? st_reg.maxspd : st_reg.level;
    ref_mag = mag32({{16{i_speed_ref[15]}}, i_speed_ref});
    req = !st_reg.s2[2];
    want = (st_reg.mode == ZCE_MODE_ZCLAMP) && req
      && (ref_mag < {18'h0, thr});
    st_next.clamp = want;
    if (want && !st_reg.clamp)
    begin
      st_next.hold = st_next.pos;
    end

    // Position loop replaces the reference while clamped
    err = st_reg.hold - st_reg.pos;
    if (!st_reg.clamp)
    begin
      st_next.cmd = i_speed_ref;
    end
    else if (mag32(err) <= 32'h1)
    begin
      st_next.cmd = 16'h0;
    end
    else
    begin
      scaled = {{16{err[31]}}, err} <<< st_reg.gain;
      st_next.cmd = sat16(scaled);
    end

    // Absolute sense and speed match
    st_next.sense = st_reg.abs_en & st_reg.sen_s2;
    st_next.term_n = 4'hf;
    st_next.term_n[st_reg.route] = !i_speed_same;

    // Divided A and B plus the passed-through index, each as a true and complement pair
    st_next.enc_o = {!st_reg.s2[3], st_reg.s2[3], !div_b, div_b, !div_a, div_a};

    // Register writes
    if (i_wr)
    begin
      case (i_addr)
        ZCE_OFS_MODE:
        begin
          st_next.mode = i_wdata[3:0];
        end
        ZCE_OFS_LEVEL:
        begin
          // Takes effect at once, no restart needed
          st_next.level = (i_wdata > {18'h0, ZCE_LEVEL_MAX}) ? ZCE_LEVEL_MAX
            : i_wdata[13:0];
        end
        ZCE_OFS_MAXSPD:
        begin
          st_next.maxspd = i_wdata[13:0];
        end
        ZCE_OFS_DIVSET:
        begin
          st_next.div_set = (i_wdata > 32'(ZCE_DIV_MAX)) ? PPR_LIM
            : div_clip(i_wdata[15:0]);
        end
        ZCE_OFS_CTRL:
        begin
          st_next.abs_en = i_wdata[ZCE_CTRL_ABS_BIT];
          st_next.route = i_wdata[ZCE_CTRL_ROUTE_LSB +: 2];
          st_next.gain = i_wdata[ZCE_CTRL_GAIN_LSB +: 4];
          // Stands in for the restart that commits a new divider
          if (i_wdata[ZCE_CTRL_APPLY_BIT])
          begin
            st_next.div_act = div_clip(st_reg.div_set);
          end
        end
        default:
        begin
          st_next.mode = st_reg.mode;
        end
      endcase
    end

    // Register reads
    st_next.rdata = 32'h0;
    if (i_rd)
    begin
      case (i_addr)
        ZCE_OFS_MODE:
        begin
          st_next.rdata = {28'h0, st_reg.mode};
        end
        ZCE_OFS_LEVEL:
        begin
          st_next.rdata = {18'h0, st_reg.level};
        end
        ZCE_OFS_MAXSPD:
        begin
          st_next.rdata = {18'h0, st_reg.maxspd};
        end
        ZCE_OFS_DIVSET:
        begin
          st_next.rdata = {16'h0, st_reg.div_set};
        end
        ZCE_OFS_CTRL:
        begin
          st_next.rdata[ZCE_CTRL_ABS_BIT] = st_reg.abs_en;
          st_next.rdata[ZCE_CTRL_ROUTE_LSB +: 2] = st_reg.route;
          st_next.rdata[ZCE_CTRL_GAIN_LSB +: 4] = st_reg.gain;
        end
        ZCE_OFS_STATUS:
        begin
          st_next.rdata[ZCE_ST_CLAMP_BIT] = st_reg.clamp;
          st_next.rdata[ZCE_ST_SENSE_BIT] = st_reg.sense;
          st_next.rdata[ZCE_ST_SAME_BIT] = !st_reg.term_n[st_reg.route];
        end
        ZCE_OFS_POS:
        begin
          st_next.rdata = st_reg.pos;
        end
        ZCE_OFS_HOLD:
        begin
          st_next.rdata = st_reg.hold;
        end
        ZCE_OFS_DIVACT:
        begin
          st_next.rdata = {16'h0, st_reg.div_act};
        end
        default:
        begin
          st_next.rdata = 32'h0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_reg <= '0;
      st_reg.s1 <= 4'h4;
      st_reg.s2 <= 4'h4;
      st_reg.mode <= ZCE_MODE_RST;
      st_reg.level <= ZCE_LEVEL_RST;
      st_reg.maxspd <= ZCE_MAXSPD_RST;
      st_reg.div_set <= ZCE_DIV_RST;
      st_reg.div_act <= div_clip(ZCE_DIV_RST);
      st_reg.route <= ZCE_ROUTE_RST;
      st_reg.gain <= ZCE_GAIN_RST;
      st_reg.term_n <= 4'hf;
      st_reg.enc_o <= 6'h2a;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_rdata = st_reg.rdata;
  assign o_speed_cmd = st_reg.cmd;
  assign o_clamp_active = st_reg.clamp;
  assign o_abs_sense = st_reg.sense;
  assign o_enc_out_a_pos = st_reg.enc_o[0];
  assign o_enc_out_a_neg = st_reg.enc_o[1];
  assign o_enc_out_b_pos = st_reg.enc_o[2];
  assign o_enc_out_b_neg = st_reg.enc_o[3];
  assign o_enc_out_index_pos = st_reg.enc_o[4];
  assign o_enc_out_index_neg = st_reg.enc_o[5];
  assign o_out_term_n = st_reg.term_n;

endmodule : zce_zero_clamp_top

/* verification/tb_zce_zero_clamp_top.sv */
// Self-checking bench for the zero clamp block
`timescale 1ns/1ns
module tb_zce_zero_clamp_top
  import zce_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic pin_n = 1'b1;
  logic sense = 1'b0;
  logic [15:0] sref = 16'h0000;
  logic same = 1'b0;
  logic step = 1'b0;
  logic dir = 1'b1;
  logic ea, eb, ex, clamp, abs_o, ap, an, bp, bn, xp, xn;
  logic [15:0] cmd;
  logic [3:0] term;
  logic [1:0] out_s, out_prev;
  int out_pos = 0;
  int failures = 0;
  int num_checks = 0;

  always #50 clk = ~clk;

  zce_enc_model #(.LINES(32)) u_enc (.i_clk(clk), .i_step(step), .i_dir(dir), .o_a(ea),
    .o_b(eb), .o_index(ex));
  zce_zero_clamp_top #(.ENC_PPR(32)) DUT (.i_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_en), .i_rd(rd_en), .o_rdata(rdata), .i_clamp_request_n(pin_n),
    .i_enc_a(ea), .i_enc_b(eb), .i_enc_index(ex), .i_absolute_sense_input(sense),
    .i_speed_ref(sref), .i_speed_same(same), .o_speed_cmd(cmd), .o_clamp_active(clamp),
    .o_abs_sense(abs_o), .o_enc_out_a_pos(ap), .o_enc_out_a_neg(an), .o_enc_out_b_pos(bp),
    .o_enc_out_b_neg(bn), .o_enc_out_index_pos(xp), .o_enc_out_index_neg(xn),
    .o_out_term_n(term));

  // Signed count of divided output states
  assign out_s = {ap, ap ^ bp};
  always @(posedge clk)
  begin
    if (out_s - out_prev == 2'h1)
      out_pos++;
    else if (out_s - out_prev == 2'h3)
      out_pos--;
    out_prev = out_s;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n
  // Pin edges kept four clocks apart
  task automatic move(input logic d, input int n);
    repeat (n)
    begin
      @(posedge clk);
      dir <= d;
      step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : move

  task automatic t_reset;
    chk({28'h0, term}, 32'hf);
    rd_chk(ZCE_OFS_MODE, 32'h0);
    rd_chk(ZCE_OFS_LEVEL, 32'ha);
    rd_chk(ZCE_OFS_MAXSPD, 32'hbb8);
    rd_chk(ZCE_OFS_DIVSET, 32'h9c4);
    rd_chk(ZCE_OFS_DIVACT, 32'h20);
    rd_chk(8'h24, 32'h0);
  endtask : t_reset
  task automatic t_clamp_mode;
    sref <= 16'h0009;
    pin_n <= 1'b0;
    wait_n(6);
    chk(clamp, 1'b0);
    wr(ZCE_OFS_MODE, 32'ha);
    wait_n(6);
    chk(clamp, 1'b1);
    rd_chk(ZCE_OFS_STATUS, 32'h1);
    sref <= 16'h000a;
    wait_n(3);
    chk(clamp, 1'b0);
    sref <= 16'h0009;
    wait_n(3);
  endtask : t_clamp_mode
  task automatic t_hold;
    move(1'b1, 1);
    wait_n(6);
    chk({16'h0, cmd}, 32'h0);
    move(1'b1, 2);
    wait_n(6);
    chk({16'h0, cmd}, 32'hfff4);
    rd_chk(ZCE_OFS_POS, 32'h3);
    rd_chk(ZCE_OFS_HOLD, 32'h0);
    move(1'b0, 3);
    wait_n(6);
    chk({16'h0, cmd}, 32'h0);
    pin_n <= 1'b1;
    wait_n(5);
    chk({16'h0, cmd}, 32'h9);
  endtask : t_hold
  task automatic t_limit;
    wr(ZCE_OFS_LEVEL, 32'h4e20);
    rd_chk(ZCE_OFS_LEVEL, 32'h2710);
    wr(ZCE_OFS_LEVEL, 32'h1388);
    sref <= 16'h0fa0;
    pin_n <= 1'b0;
    wait_n(6);
    chk(clamp, 1'b0);
    sref <= 16'h07d0;
    wait_n(3);
    chk(clamp, 1'b1);
    pin_n <= 1'b1;
    wait_n(5);
  endtask : t_limit
  task automatic t_divider;
    int base;
    base = out_pos;
    move(1'b1, 4);
    wait_n(8);
    chk(out_pos - base, 32'h4);
    wr(ZCE_OFS_DIVSET, 32'h5);
    rd_chk(ZCE_OFS_DIVSET, 32'h10);
    move(1'b1, 4);
    wait_n(8);
    chk(out_pos - base, 32'h8);
    wr(ZCE_OFS_CTRL, 32'h202);
    rd_chk(ZCE_OFS_DIVACT, 32'h10);
    move(1'b1, 8);
    wait_n(8);
    chk(out_pos - base, 32'hc);
    move(1'b0, 8);
    wait_n(8);
    chk(out_pos - base, 32'h8);
  endtask : t_divider
  task automatic t_sense;
    sense <= 1'b1;
    wr(ZCE_OFS_CTRL, 32'h200);
    wait_n(6);
    chk(abs_o, 1'b0);
    wr(ZCE_OFS_CTRL, 32'h201);
    wait_n(6);
    chk(abs_o, 1'b1);
  endtask : t_sense
  task automatic t_match;
    for (int r = 0; r < 4; r++)
    begin
      wr(ZCE_OFS_CTRL, 32'h200 | (r << 4));
      same <= 1'b1;
      wait_n(3);
      chk({28'h0, term}, {28'h0, ~(4'h1 << r)});
      rd_chk(ZCE_OFS_STATUS, 32'h4);
      same <= 1'b0;
      wait_n(3);
      chk({28'h0, term}, 32'hf);
    end
  endtask : t_match

  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    #500000;
    failures++;
    end_sim();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_n(1);
    t_reset();
    t_clamp_mode();
    t_hold();
    t_limit();
    t_divider();
    t_sense();
    t_match();
    end_sim();
  end
endmodule : tb_zce_zero_clamp_top

/* verification/zce_enc_model.sv */
// Quadrature encoder model for the far side
`timescale 1ns/1ns
module zce_enc_model
#(
  parameter int LINES = 32
)
(
  input wire logic i_clk, // Clock
  input wire logic i_step, // Move one edge
  input wire logic i_dir, // High forward
  output logic o_a, // Phase A
  output logic o_b, // Phase B
  output logic o_index // Index, once per rev
);
  logic [15:0] pos_reg = 16'h0000;
  always @(posedge i_clk)
  begin
    if (i_step)
    begin
      pos_reg <= i_dir ? pos_reg + 16'h0001 : pos_reg - 16'h0001;
    end
  end
  // Gray order: one phase changes per edge
  assign o_a = pos_reg[1];
  assign o_b = pos_reg[1] ^ pos_reg[0];
  // Controller never homes on this pulse here
  assign o_index = (int'(pos_reg) % (4 * LINES)) == 0;
endmodule : zce_enc_model

/* verification/zce_monitor.sv */
// Port-level checker for the zero clamp block
`timescale 1ns/1ns
module zce_monitor
  import zce_pkg::*;
#(
  parameter int ENC_PPR = ZCE_ENC_PPR_DEF
)
(
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_clamp_request_n, // Clamp pin
  input wire logic i_enc_index, // Index pin
  input wire logic i_absolute_sense_input, // Sense pin
  input wire logic [15:0] i_speed_ref, // Reference
  input wire logic i_speed_same, // Same speed
  input logic [15:0] o_speed_cmd, // Command
  input logic o_clamp_active, // Locked
  input logic o_abs_sense, // Sense out
  input logic o_enc_out_a_pos, // A true
  input logic o_enc_out_a_neg, // A complement
  input logic o_enc_out_b_pos, // B true
  input logic o_enc_out_b_neg, // B complement
  input logic o_enc_out_index_pos, // Index true
  input logic o_enc_out_index_neg, // Index complement
  input logic [3:0] o_out_term_n // Terminals
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // ----------------------------------------
  // Clamp sequences
  // ----------------------------------------
  sequence s_release;
    $rose(i_clamp_request_n);
  endsequence
  sequence s_lock;
    $rose(o_clamp_active);
  endsequence

  a_diff_pairs: assert property ((o_enc_out_a_neg == !o_enc_out_a_pos) &&
    (o_enc_out_b_neg == !o_enc_out_b_pos) && (o_enc_out_index_neg == !o_enc_out_index_pos))
    else $error("output pair not complementary");
  a_index_pass: assert property (!$past(i_rst, 3) && !$past(i_rst, 2) && !$past(i_rst) |->
    o_enc_out_index_pos == $past(i_enc_index, 3)) else $error("index output wrong");
  a_quad_gray: assert property (!($changed(o_enc_out_a_pos) && $changed(o_enc_out_b_pos)))
    else $error("both phases moved at once");
  a_cmd_follow: assert property ($past(!i_rst) && !$past(o_clamp_active) &&
    !o_clamp_active |-> o_speed_cmd == $past(i_speed_ref))
    else $error("command not following reference");
  a_release_clamp: assert property (s_release |-> ##3 !o_clamp_active)
    else $error("clamp held after pin release");
  a_lock_zero: assert property (s_lock |-> ##1 (o_speed_cmd == 16'h0000))
    else $error("command not zero at lock");
  a_lock_pin: assert property (o_clamp_active |-> !$past(i_clamp_request_n, 3))
    else $error("clamp without low pin");
  a_term_cause: assert property (o_out_term_n != 4'hf |-> $past(i_speed_same))
    else $error("terminal low without same speed");
  a_term_one: assert property ($countones(o_out_term_n) >= 3)
    else $error("more than one terminal low");
  a_abs_gate: assert property (o_abs_sense |-> $past(i_absolute_sense_input, 3))
    else $error("sense out without sense pin");
endmodule : zce_monitor

bind zce_zero_clamp_top zce_monitor #(.ENC_PPR(ENC_PPR)) u_mon (.i_clk(i_clk), .i_rst(i_rst),
  .i_clamp_request_n(i_clamp_request_n), .i_enc_index(i_enc_index),
  .i_absolute_sense_input(i_absolute_sense_input), .i_speed_ref(i_speed_ref),
  .i_speed_same(i_speed_same), .o_speed_cmd(o_speed_cmd), .o_clamp_active(o_clamp_active),
  .o_abs_sense(o_abs_sense), .o_enc_out_a_pos(o_enc_out_a_pos),
  .o_enc_out_a_neg(o_enc_out_a_neg), .o_enc_out_b_pos(o_enc_out_b_pos),
  .o_enc_out_b_neg(o_enc_out_b_neg), .o_enc_out_index_pos(o_enc_out_index_pos),
  .o_enc_out_index_neg(o_enc_out_index_neg), .o_out_term_n(o_out_term_n));
